// ==== tx_desc_pkg.sv ====
package tx_desc_pkg;
  // descriptor word 0 fields
  localparam int OWN_BIT = 15;
  localparam int COPROC_BIT = 14;
  localparam int FIRST_BIT = 13;
  localparam int LAST_BIT = 12;
  localparam int UI_BIT = 11;
  localparam int SUPPRESS_BIT = 10;
  localparam int PF_BIT = 8;
  localparam int HI_ADDR_MSB = 7;
  localparam logic [15:0] OWN_MASK = 16'h0001 << OWN_BIT;
  // descriptor layout: four 16-bit words, eight bytes per entry
  localparam logic [1:0] WORD0 = 2'h0;
  localparam logic [1:0] WORD1 = 2'h1;
  localparam logic [1:0] WORD2 = 2'h2;
  localparam logic [1:0] WORD3 = 2'h3;
  localparam logic [23:0] WORD_STEP = 24'h000002;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_BASE = 8'h04;
  localparam logic [7:0] REG_LEN = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_MASK = 8'h10;
  localparam logic [7:0] REG_CUR = 8'h14;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_XPARENT_BIT = 1;
  localparam int EVT_DONE = 0;
  localparam int EVT_CHAIN = 1;
  localparam int EVT_W = 2;
  // idle poll interval while the current descriptor is still the host's
  localparam int CLK_NS = 5;
  localparam int POLL_NS = 320;
  localparam logic [7:0] POLL_CYCLES = 8'((POLL_NS + CLK_NS - 1) / CLK_NS);
  typedef enum logic [10:0] {
    st_idle = 11'h001, st_fetch = 11'h002, st_check = 11'h004, st_read = 11'h008,
    st_send = 11'h010, st_done = 11'h020, st_drain = 11'h040, st_ack = 11'h080,
    st_rel_rd = 11'h100, st_rel_wr = 11'h200, st_poll = 11'h400
  } state_t;
endpackage : tx_desc_pkg

// ==== tx_desc_ifs.sv ====
interface ctrl_if;
  logic enable;
  logic transparent;
  logic [23:0] base;
  logic [7:0] ring_len;
  logic [7:0] cur_idx;
  logic [tx_desc_pkg::EVT_W-1:0] evt;
  modport regs(output enable, transparent, base, ring_len, input cur_idx, evt);
  modport core(input enable, transparent, base, ring_len, output cur_idx, evt);
endinterface : ctrl_if

interface feed_if;
  logic push;
  logic [15:0] word;
  logic two;
  logic ready;
  logic empty;
  modport src(output push, word, two, input ready, empty);
  modport sink(input push, word, two, output ready, empty);
endinterface : feed_if

// ==== tx_byte_unpack.sv ====
module tx_byte_unpack (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  feed_if.sink feed,
  output logic [7:0] byte_out,
  output logic valid_out,
  input wire logic ready_in
);
  logic [15:0] hold_q, hold_d;
  logic [1:0] cnt_q, cnt_d;
  logic [7:0] byte_q, byte_d;
  logic valid_q, valid_d;

  assign feed.ready = (cnt_q == 2'h0);
  assign feed.empty = (cnt_q == 2'h0) && !valid_q;
  assign byte_out = byte_q;
  assign valid_out = valid_q;

  // low byte of each memory word goes out first
  always_comb begin
    hold_d = hold_q;
    cnt_d = cnt_q;
    byte_d = byte_q;
    valid_d = valid_q;
    if (valid_q && ready_in) begin
      valid_d = 1'b0;
    end
    if (feed.push && cnt_q == 2'h0) begin
      hold_d = feed.word;
      cnt_d = feed.two ? 2'h2 : 2'h1;
    end else if (!valid_d && cnt_q != 2'h0) begin
      byte_d = hold_q[7:0];
      hold_d = {8'h00, hold_q[15:8]};
      cnt_d = cnt_q - 2'h1;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      hold_q <= 16'h0000;
      cnt_q <= 2'h0;
      byte_q <= 8'h00;
      valid_q <= 1'b0;
    end else begin
      hold_q <= hold_d;
      cnt_q <= cnt_d;
      byte_q <= byte_d;
      valid_q <= valid_d;
    end
  end
endmodule : tx_byte_unpack

// ==== tx_reg_slave.sv ====
module tx_reg_slave (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  ctrl_if.regs ctl
);
  logic [31:0] ctrl_q, ctrl_d, base_q, base_d, len_q, len_d;
  logic [31:0] stat_q, stat_d, mask_q, mask_d, rdata_q, rdata_d;
  logic wait_q, wait_d, irq_q, irq_d, wr;

  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : be_merge

  assign ctl.enable = ctrl_q[tx_desc_pkg::CTRL_EN_BIT];
  assign ctl.transparent = ctrl_q[tx_desc_pkg::CTRL_XPARENT_BIT];
  assign ctl.base = base_q[23:0];
  assign ctl.ring_len = len_q[7:0];
  assign avs_readdata_out = rdata_q;
  assign avs_waitrequest_out = wait_q;
  assign irq_out = irq_q;
  assign wr = avs_write_in && !wait_q;

  always_comb begin
    ctrl_d = ctrl_q;
    base_d = base_q;
    len_d = len_q;
    mask_d = mask_q;
    stat_d = stat_q;
    rdata_d = rdata_q;
    // one wait cycle per access, then a single answer cycle
    wait_d = !((avs_read_in || avs_write_in) && wait_q);
    if (avs_read_in && wait_q) begin
      unique case (avs_address_in)
        tx_desc_pkg::REG_CTRL: rdata_d = ctrl_q;
        tx_desc_pkg::REG_BASE: rdata_d = base_q;
        tx_desc_pkg::REG_LEN: rdata_d = len_q;
        tx_desc_pkg::REG_STAT: rdata_d = stat_q;
        tx_desc_pkg::REG_MASK: rdata_d = mask_q;
        tx_desc_pkg::REG_CUR: rdata_d = {24'h000000, ctl.cur_idx};
        default: rdata_d = 32'h00000000;
      endcase
    end
    if (wr) begin
      unique case (avs_address_in)
        tx_desc_pkg::REG_CTRL: ctrl_d = be_merge(ctrl_q, avs_writedata_in, avs_byteenable_in) & 32'h00000003;
        tx_desc_pkg::REG_BASE: base_d = be_merge(base_q, avs_writedata_in, avs_byteenable_in) & 32'h00fffffe;
        tx_desc_pkg::REG_LEN: len_d = be_merge(len_q, avs_writedata_in, avs_byteenable_in) & 32'h000000ff;
        tx_desc_pkg::REG_MASK: mask_d = be_merge(mask_q, avs_writedata_in, avs_byteenable_in) & 32'h00000003;
        tx_desc_pkg::REG_STAT: stat_d = stat_q & ~be_merge(32'h00000000, avs_writedata_in, avs_byteenable_in);
        default: ;
      endcase
    end
    // a new event in the clearing cycle survives the clear
    stat_d[tx_desc_pkg::EVT_W-1:0] = stat_d[tx_desc_pkg::EVT_W-1:0] | ctl.evt;
    irq_d = |(stat_d & mask_d);
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ctrl_q <= 32'h00000000;
      base_q <= 32'h00000000;
      len_q <= 32'h00000000;
      stat_q <= 32'h00000000;
      mask_q <= 32'h00000000;
      rdata_q <= 32'h00000000;
      wait_q <= 1'b1;
      irq_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      base_q <= base_d;
      len_q <= len_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      wait_q <= wait_d;
      irq_q <= irq_d;
    end
  end
endmodule : tx_reg_slave

// ==== tx_descriptor_handling.sv ====
// What this block does
// - set owner bit means the controller owns
// - coprocessor owner bit is never looked at
// - last flag ends frame; both flags: single
// - unnumbered flag selects UI frame type
// - suppress flag blocks done interrupt on release
// - poll/final value goes out with frame
// - upper address byte from word zero, untouched
// - lower address from word one, 16 bits
// - buffer size word is never read
// - word three negated gives transmit length
// - transparent mode releases without waiting acknowledge
//
// The address map and the Avalon-MM slave port were chosen for this implementation.
module tx_descriptor_handling (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic irq_out,
  output logic mem_req_out,
  output logic mem_we_out,
  output logic [23:0] mem_addr_out,
  output logic [15:0] mem_wdata_out,
  input wire logic [15:0] mem_rdata_in,
  input wire logic mem_ack_in,
  output logic tx_frame_start_out,
  output logic tx_ui_frame_out,
  output logic tx_poll_final_out,
  output logic [7:0] tx_byte_out,
  output logic tx_byte_valid_out,
  input wire logic tx_byte_ready_in,
  output logic tx_frame_end_out,
  input wire logic link_ack_in
);
  ctrl_if ctl ();
  feed_if feed ();

  tx_desc_pkg::state_t state_q, state_d;
  logic [1:0] wsel_q, wsel_d;
  logic [15:0] w0_q, w0_d, w1_q, w1_d, remain_q, remain_d, rel_word_q, rel_word_d;
  logic [23:0] daddr_q, daddr_d, mem_addr_q, mem_addr_d;
  logic [15:0] mem_wdata_q, mem_wdata_d;
  logic mem_req_q, mem_req_d, mem_we_q, mem_we_d;
  logic in_frame_q, in_frame_d;
  logic [7:0] cur_q, cur_d, first_q, first_d, nbuf_q, nbuf_d, rel_idx_q, rel_idx_d, rel_left_q, rel_left_d;
  logic [7:0] poll_q, poll_d;
  logic start_q, start_d, ui_q, ui_d, pf_q, pf_d, end_q, end_d;
  logic [tx_desc_pkg::EVT_W-1:0] evt_q, evt_d;

  function automatic logic [23:0] desc_addr(input logic [23:0] base, input logic [7:0] idx,
                                            input logic [1:0] ws);
    return base + {13'h0000, idx, ws, 1'b0};
  endfunction : desc_addr

  function automatic logic [7:0] next_idx(input logic [7:0] idx, input logic [7:0] len);
    return (idx + 8'h01 >= len) ? 8'h00 : idx + 8'h01;
  endfunction : next_idx

  tx_reg_slave i_tx_reg_slave (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .irq_out(irq_out),
    .ctl(ctl.regs)
  );

  tx_byte_unpack i_tx_byte_unpack (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .feed(feed.sink),
    .byte_out(tx_byte_out),
    .valid_out(tx_byte_valid_out),
    .ready_in(tx_byte_ready_in)
  );

  assign ctl.cur_idx = cur_q;
  assign ctl.evt = evt_q;
  // data words go straight from memory into the unpacker, so no extra word buffer
  assign feed.push = (state_q == tx_desc_pkg::st_read) && mem_ack_in;
  assign feed.word = mem_rdata_in;
  assign feed.two = (remain_q != 16'h0001);
  assign mem_req_out = mem_req_q;
  assign mem_we_out = mem_we_q;
  assign mem_addr_out = mem_addr_q;
  assign mem_wdata_out = mem_wdata_q;
  assign tx_frame_start_out = start_q;
  assign tx_ui_frame_out = ui_q;
  assign tx_poll_final_out = pf_q;
  assign tx_frame_end_out = end_q;

  always_comb begin
    state_d = state_q;
    wsel_d = wsel_q;
    w0_d = w0_q;
    w1_d = w1_q;
    remain_d = remain_q;
    rel_word_d = rel_word_q;
    daddr_d = daddr_q;
    mem_addr_d = mem_addr_q;
    mem_wdata_d = mem_wdata_q;
    mem_req_d = mem_req_q;
    mem_we_d = mem_we_q;
    in_frame_d = in_frame_q;
    cur_d = cur_q;
    first_d = first_q;
    nbuf_d = nbuf_q;
    rel_idx_d = rel_idx_q;
    rel_left_d = rel_left_q;
    poll_d = poll_q;
    start_d = 1'b0;
    end_d = 1'b0;
    ui_d = ui_q;
    pf_d = pf_q;
    evt_d = '0;
    unique case (state_q)
      tx_desc_pkg::st_idle: begin
        if (ctl.enable) begin
          mem_req_d = 1'b1;
          mem_we_d = 1'b0;
          wsel_d = tx_desc_pkg::WORD0;
          mem_addr_d = desc_addr(ctl.base, cur_q, tx_desc_pkg::WORD0);
          state_d = tx_desc_pkg::st_fetch;
        end
      end
      tx_desc_pkg::st_fetch: begin
        if (mem_ack_in) begin
          mem_req_d = 1'b0;
          unique case (wsel_q)
            tx_desc_pkg::WORD0: begin
              w0_d = mem_rdata_in;
              // only the owner bit decides; the coprocessor bit is not consulted
              if (!mem_rdata_in[tx_desc_pkg::OWN_BIT]) begin
                poll_d = tx_desc_pkg::POLL_CYCLES;
                state_d = tx_desc_pkg::st_poll;
              end else begin
                mem_req_d = 1'b1;
                wsel_d = tx_desc_pkg::WORD1;
                mem_addr_d = desc_addr(ctl.base, cur_q, tx_desc_pkg::WORD1);
              end
            end
            tx_desc_pkg::WORD1: begin
              w1_d = mem_rdata_in;
              // word two holds the buffer size and is skipped
              mem_req_d = 1'b1;
              wsel_d = tx_desc_pkg::WORD3;
              mem_addr_d = desc_addr(ctl.base, cur_q, tx_desc_pkg::WORD3);
            end
            default: begin
              remain_d = 16'h0000 - mem_rdata_in;
              state_d = tx_desc_pkg::st_check;
            end
          endcase
        end
      end
      tx_desc_pkg::st_poll: begin
        poll_d = poll_q - 8'h01;
        if (poll_q == 8'h00 || !ctl.enable) begin
          state_d = tx_desc_pkg::st_idle;
        end
      end
      tx_desc_pkg::st_check: begin
        // a buffer without the first flag outside a frame, or a new first flag inside one
        if (in_frame_q == w0_q[tx_desc_pkg::FIRST_BIT]) begin
          evt_d[tx_desc_pkg::EVT_CHAIN] = 1'b1;
        end
        if (!in_frame_q || w0_q[tx_desc_pkg::FIRST_BIT]) begin
          first_d = cur_q;
          nbuf_d = 8'h00;
          start_d = 1'b1;
          ui_d = w0_q[tx_desc_pkg::UI_BIT];
          pf_d = w0_q[tx_desc_pkg::PF_BIT];
        end
        in_frame_d = 1'b1;
        daddr_d = {w0_q[tx_desc_pkg::HI_ADDR_MSB:0], w1_q};
        if (remain_q == 16'h0000) begin
          state_d = tx_desc_pkg::st_done;
        end else begin
          mem_req_d = 1'b1;
          mem_addr_d = {w0_q[tx_desc_pkg::HI_ADDR_MSB:0], w1_q};
          state_d = tx_desc_pkg::st_read;
        end
      end
      tx_desc_pkg::st_read: begin
        if (mem_ack_in) begin
          mem_req_d = 1'b0;
          remain_d = feed.two ? remain_q - 16'h0002 : 16'h0000;
          daddr_d = daddr_q + tx_desc_pkg::WORD_STEP;
          state_d = tx_desc_pkg::st_send;
        end
      end
      tx_desc_pkg::st_send: begin
        if (feed.ready) begin
          if (remain_q == 16'h0000) begin
            state_d = tx_desc_pkg::st_done;
          end else begin
            mem_req_d = 1'b1;
            mem_addr_d = daddr_q;
            state_d = tx_desc_pkg::st_read;
          end
        end
      end
      tx_desc_pkg::st_done: begin
        nbuf_d = nbuf_q + 8'h01;
        cur_d = next_idx(cur_q, ctl.ring_len);
        if (w0_q[tx_desc_pkg::LAST_BIT]) begin
          in_frame_d = 1'b0;
          state_d = tx_desc_pkg::st_drain;
        end else begin
          state_d = tx_desc_pkg::st_idle;
        end
      end
      tx_desc_pkg::st_drain: begin
        if (feed.empty) begin
          end_d = 1'b1;
          state_d = tx_desc_pkg::st_ack;
        end
      end
      tx_desc_pkg::st_ack: begin
        if (ctl.transparent || link_ack_in) begin
          rel_idx_d = first_q;
          rel_left_d = nbuf_q;
          mem_req_d = 1'b1;
          mem_we_d = 1'b0;
          mem_addr_d = desc_addr(ctl.base, first_q, tx_desc_pkg::WORD0);
          state_d = tx_desc_pkg::st_rel_rd;
        end
      end
      tx_desc_pkg::st_rel_rd: begin
        if (mem_ack_in) begin
          rel_word_d = mem_rdata_in;
          mem_we_d = 1'b1;
          mem_wdata_d = mem_rdata_in & ~tx_desc_pkg::OWN_MASK;
          state_d = tx_desc_pkg::st_rel_wr;
        end
      end
      tx_desc_pkg::st_rel_wr: begin
        if (mem_ack_in) begin
          mem_we_d = 1'b0;
          evt_d[tx_desc_pkg::EVT_DONE] = !rel_word_q[tx_desc_pkg::SUPPRESS_BIT];
          rel_left_d = rel_left_q - 8'h01;
          rel_idx_d = next_idx(rel_idx_q, ctl.ring_len);
          if (rel_left_q == 8'h01) begin
            mem_req_d = 1'b0;
            state_d = tx_desc_pkg::st_idle;
          end else begin
            mem_addr_d = desc_addr(ctl.base, rel_idx_d, tx_desc_pkg::WORD0);
            state_d = tx_desc_pkg::st_rel_rd;
          end
        end
      end
      default: begin
        state_d = tx_desc_pkg::st_idle;
        mem_req_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state_q <= tx_desc_pkg::st_idle;
      wsel_q <= 2'h0;
      w0_q <= 16'h0000;
      w1_q <= 16'h0000;
      remain_q <= 16'h0000;
      rel_word_q <= 16'h0000;
      daddr_q <= 24'h000000;
      mem_addr_q <= 24'h000000;
      mem_wdata_q <= 16'h0000;
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      in_frame_q <= 1'b0;
      cur_q <= 8'h00;
      first_q <= 8'h00;
      nbuf_q <= 8'h00;
      rel_idx_q <= 8'h00;
      rel_left_q <= 8'h00;
      poll_q <= 8'h00;
      start_q <= 1'b0;
      ui_q <= 1'b0;
      pf_q <= 1'b0;
      end_q <= 1'b0;
      evt_q <= '0;
    end else begin
      state_q <= state_d;
      wsel_q <= wsel_d;
      w0_q <= w0_d;
      w1_q <= w1_d;
      remain_q <= remain_d;
      rel_word_q <= rel_word_d;
      daddr_q <= daddr_d;
      mem_addr_q <= mem_addr_d;
      mem_wdata_q <= mem_wdata_d;
      mem_req_q <= mem_req_d;
      mem_we_q <= mem_we_d;
      in_frame_q <= in_frame_d;
      cur_q <= cur_d;
      first_q <= first_d;
      nbuf_q <= nbuf_d;
      rel_idx_q <= rel_idx_d;
      rel_left_q <= rel_left_d;
      poll_q <= poll_d;
      start_q <= start_d;
      ui_q <= ui_d;
      pf_q <= pf_d;
      end_q <= end_d;
      evt_q <= evt_d;
    end
  end

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  unowned_poll_a: assert property (
    state_q == tx_desc_pkg::st_fetch && mem_ack_in && wsel_q == tx_desc_pkg::WORD0 &&
    !mem_rdata_in[tx_desc_pkg::OWN_BIT] |=> state_q == tx_desc_pkg::st_poll && !mem_req_q)
    else $error("unowned descriptor was not left alone");
  owned_only_a: assert property (
    $rose(tx_frame_start_out) |-> $past(w0_q[tx_desc_pkg::OWN_BIT]))
    else $error("frame started from a descriptor not owned");
  ack_wait_a: assert property (
    state_q == tx_desc_pkg::st_ack && !ctl.transparent && !link_ack_in |=> state_q == tx_desc_pkg::st_ack)
    else $error("released before acknowledge");
  xparent_release_a: assert property (
    state_q == tx_desc_pkg::st_ack && ctl.transparent |=> state_q == tx_desc_pkg::st_rel_rd && mem_req_q)
    else $error("transparent release did not start");
  release_write_a: assert property (
    mem_req_q && mem_we_q |-> mem_wdata_q == (rel_word_q & ~tx_desc_pkg::OWN_MASK))
    else $error("release write changed more than the owner bit");
  irq_suppress_a: assert property (
    state_q == tx_desc_pkg::st_rel_wr && mem_ack_in |=> evt_q[tx_desc_pkg::EVT_DONE] ==
    !$past(rel_word_q[tx_desc_pkg::SUPPRESS_BIT]))
    else $error("done event does not follow suppress flag");
  size_skip_a: assert property (
    state_q == tx_desc_pkg::st_fetch && mem_req_q |-> wsel_q != tx_desc_pkg::WORD2)
    else $error("buffer size word was fetched");
  buf_addr_a: assert property (
    state_q == tx_desc_pkg::st_check && remain_q != 16'h0000 |=>
    mem_addr_q == {w0_q[tx_desc_pkg::HI_ADDR_MSB:0], w1_q} && state_q == tx_desc_pkg::st_read)
    else $error("wrong buffer address");
  frame_kind_a: assert property (
    tx_frame_start_out |-> tx_ui_frame_out == w0_q[tx_desc_pkg::UI_BIT] &&
    tx_poll_final_out == w0_q[tx_desc_pkg::PF_BIT])
    else $error("frame type or poll/final mismatch");
  frame_end_a: assert property (
    state_q == tx_desc_pkg::st_done && w0_q[tx_desc_pkg::LAST_BIT] |=> !in_frame_q ##[1:20] tx_frame_end_out)
    else $error("last buffer did not close the frame");

  chain_release_c: cover property (state_q == tx_desc_pkg::st_ack && nbuf_q > 8'h01 ##1 link_ack_in);
  xparent_c: cover property (state_q == tx_desc_pkg::st_ack && ctl.transparent);
  poll_c: cover property (state_q == tx_desc_pkg::st_poll ##[1:100] state_q == tx_desc_pkg::st_fetch);
  irq_c: cover property (evt_q[tx_desc_pkg::EVT_DONE] ##1 irq_out);
endmodule : tx_descriptor_handling

// ==== tx_mem_model.sv ====
module tx_mem_model (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic mem_req_in,
  input wire logic mem_we_in,
  input wire logic [23:0] mem_addr_in,
  input wire logic [15:0] mem_wdata_in,
  input wire logic [3:0] lat_in,
  output logic [15:0] mem_rdata_out,
  output logic mem_ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // only address bits 8:1 decode, so the upper byte aliases
  logic [15:0] mem [0:255];
  logic [3:0] wait_q;
  always @(posedge ref_clk_in) begin
    if (rst_in) begin
      mem_ack_out <= 1'b0;
      wait_q <= 4'h0;
      mem_rdata_out <= 16'h0000;
    end else if (mem_req_in && !mem_ack_out && wait_q >= lat_in) begin
      mem_ack_out <= 1'b1;
      wait_q <= 4'h0;
      if (mem_we_in) begin
        mem[mem_addr_in[8:1]] <= mem_wdata_in;
      end else begin
        mem_rdata_out <= mem[mem_addr_in[8:1]];
      end
    end else begin
      mem_ack_out <= 1'b0;
      wait_q <= (mem_req_in && !mem_ack_out) ? wait_q + 4'h1 : 4'h0;
      // stale data must not look valid outside the ack cycle
      mem_rdata_out <= ~mem_rdata_out;
    end
  end
endmodule : tx_mem_model

// ==== tx_descriptor_handling_tb.sv ====
module tx_descriptor_handling_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] av_a = 8'h00;
  logic av_rd = 1'b0;
  logic av_wr = 1'b0;
  logic [31:0] av_d = 32'h0;
  logic [31:0] av_q, r;
  logic wreq, irq, mreq, mwe, mack, fstart, ui, pf, bval, fend;
  logic [23:0] maddr;
  logic [15:0] mwd, mrd;
  logic [7:0] bdat;
  logic bready = 1'b0;
  logic lack = 1'b0;
  logic [3:0] lat = 4'h0;
  logic st_d = 1'b0;
  int err_total = 0, tests_run = 0, cyc = 0, n_start = 0, n_end = 0;
  logic [7:0] got_b [$];
  logic [1:0] got_f [$];
  logic [23:0] got_a [$];
  logic [7:0] exp_b [6] = '{8'h11, 8'h22, 8'h33, 8'h33, 8'h44, 8'h55};
  always #2.5 clk = ~clk;
  tx_descriptor_handling i_tx_descriptor_handling (.ref_clk_in(clk), .rst_in(rst), .avs_address_in(av_a),
    .avs_read_in(av_rd), .avs_write_in(av_wr), .avs_writedata_in(av_d), .avs_byteenable_in(4'hf),
    .avs_readdata_out(av_q), .avs_waitrequest_out(wreq), .irq_out(irq), .mem_req_out(mreq), .mem_we_out(mwe),
    .mem_addr_out(maddr), .mem_wdata_out(mwd), .mem_rdata_in(mrd), .mem_ack_in(mack), .tx_frame_start_out(fstart),
    .tx_ui_frame_out(ui), .tx_poll_final_out(pf), .tx_byte_out(bdat), .tx_byte_valid_out(bval),
    .tx_byte_ready_in(bready), .tx_frame_end_out(fend), .link_ack_in(lack));
  tx_mem_model i_tx_mem_model (.ref_clk_in(clk), .rst_in(rst), .mem_req_in(mreq), .mem_we_in(mwe),
    .mem_addr_in(maddr), .mem_wdata_in(mwd), .lat_in(lat), .mem_rdata_out(mrd), .mem_ack_out(mack));
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk) begin
    cyc <= cyc + 1;
    bready <= cyc[1]; // sink stalls half the time
    st_d <= fstart;
    if (fstart) n_start <= n_start + 1;
    if (fend) n_end <= n_end + 1;
    if (st_d) got_f.push_back({ui, pf});
    if (bval && bready) got_b.push_back(bdat);
    if (mack && !mwe && maddr[23:16] != 8'h00) got_a.push_back(maddr);
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic av(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    av_a <= a;
    av_wr <= wr;
    av_rd <= !wr;
    av_d <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    r = av_q;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
  endtask : av
  // host fills everything first and hands over word 0 last
  task automatic put_desc(input int i, input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w3);
    i_tx_mem_model.mem[128 + i * 4 + 1] = w1;
    i_tx_mem_model.mem[128 + i * 4 + 2] = 16'hbeef;
    i_tx_mem_model.mem[128 + i * 4 + 3] = w3;
    i_tx_mem_model.mem[128 + i * 4] = w0;
  endtask : put_desc
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    av(1'b0, tx_desc_pkg::REG_CTRL, 32'h0);
    chk(r, 32'h0);
    av(1'b1, 8'h18, 32'hffffffff);
    av(1'b0, 8'h18, 32'h0);
    chk(r, 32'h0);
    i_tx_mem_model.mem[8'h20] = 16'h2211;
    i_tx_mem_model.mem[8'h21] = 16'h0033;
    i_tx_mem_model.mem[8'h30] = 16'h4433;
    i_tx_mem_model.mem[8'h38] = 16'h0055;
    // later ring entries stay host-owned until handed over, so the first poll does not read unknowns
    i_tx_mem_model.mem[8'h84] = 16'h0000;
    i_tx_mem_model.mem[8'h88] = 16'h0000;
    i_tx_mem_model.mem[8'h8c] = 16'h0000;
    put_desc(0, 16'hb15a, 16'h0040, 16'hfffd);
    av(1'b1, tx_desc_pkg::REG_BASE, 32'h100);
    av(1'b1, tx_desc_pkg::REG_LEN, 32'h4);
    av(1'b1, tx_desc_pkg::REG_MASK, 32'h1);
    av(1'b1, tx_desc_pkg::REG_CTRL, 32'h1);
    wait (n_end == 1);
    repeat (30) @(posedge clk);
    chk(i_tx_mem_model.mem[8'h80][15], 1);
    lack <= 1'b1;
    @(posedge clk);
    lack <= 1'b0;
    wait (i_tx_mem_model.mem[8'h80][15] === 1'b0);
    chk(i_tx_mem_model.mem[8'h80], 16'h315a);
    // done event reaches status two edges after the release write lands
    repeat (2) @(posedge clk);
    av(1'b0, tx_desc_pkg::REG_STAT, 32'h0);
    chk(r, 32'h1);
    chk(irq, 1'b1);
    av(1'b1, tx_desc_pkg::REG_MASK, 32'h0);
    av(1'b0, tx_desc_pkg::REG_STAT, 32'h0);
    chk(irq, 1'b0);
    av(1'b1, tx_desc_pkg::REG_STAT, 32'h1);
    av(1'b1, tx_desc_pkg::REG_MASK, 32'h1);
    av(1'b0, tx_desc_pkg::REG_STAT, 32'h0);
    chk(r, 32'h0);
    $display("single acknowledged frame done");
    lat <= 4'h5;
    av(1'b1, tx_desc_pkg::REG_CTRL, 32'h3);
    put_desc(2, 16'hdc5a, 16'h0070, 16'hffff);
    put_desc(1, 16'hac5a, 16'h0060, 16'hfffe);
    wait (n_end == 2);
    wait (i_tx_mem_model.mem[8'h88][15] === 1'b0);
    chk(i_tx_mem_model.mem[8'h84], 16'h2c5a);
    chk(i_tx_mem_model.mem[8'h88], 16'h5c5a);
    av(1'b0, tx_desc_pkg::REG_STAT, 32'h0);
    chk(r, 32'h0);
    chk(irq, 1'b0);
    av(1'b0, tx_desc_pkg::REG_CUR, 32'h0);
    chk(r, 32'h3);
    repeat (300) @(posedge clk);
    chk(n_start, 2);
    chk(got_b.size(), 6);
    foreach (exp_b[i]) chk(got_b[i], exp_b[i]);
    chk(got_f[0], 2'b01);
    chk(got_f[1], 2'b10);
    chk(got_a[0], 24'h5a0040);
    chk(got_a[2], 24'h5a0060);
    chk(got_a[3], 24'h5a0070);
    $display("chained transparent frame done");
    // last-only buffer with no frame open: chain error, still sent and released
    put_desc(3, 16'h985a, 16'h0080, 16'h0000);
    wait (n_end == 3);
    wait (i_tx_mem_model.mem[8'h8c][15] === 1'b0);
    repeat (2) @(posedge clk);
    chk(i_tx_mem_model.mem[8'h8c], 16'h185a);
    av(1'b0, tx_desc_pkg::REG_STAT, 32'h0);
    chk(r, 32'h3);
    chk(irq, 1'b1);
    chk(got_f[2], 2'b10);
    $display("unopened chain flagged");
    tally_and_finish();
  end
endmodule : tx_descriptor_handling_tb
